/* rtl/core_exec_pkg.sv */
// Function
// - A call pushes the current program counter plus one onto the return stack.
// - A call loads its 11-bit literal into counter bits 10:0, taking two cycles.
// - A call takes counter bits 12:11 from upper latch bits 4:3.
// - Watchdog kick clears the watchdog counter and its prescaler to zero.
// - Watchdog kick sets expired flag and sleep status flag and pulses the kick output; nothing else changes.
// - Zero register op writes 00h to file register f and sets zero flag.
// - Zero accumulator op writes 00h to the accumulator and sets zero flag.
// - Invert register op complements file register f; only zero flag affected.
// - Direction bit 0 sends result to accumulator, 1 back to register.
// - Decrement register op subtracts one from f; only zero flag affected.
// - Rotate left through carry: old carry into bit 0, bit 7 to carry.
package core_exec_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int LIT_W = 11;
  localparam int FADDR_W = 7;
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;
  localparam int LATCH_W = 8;
  localparam int LATCH_LO = 3;
  localparam int LATCH_HI = 4;
  localparam int CALL_CYCLES = 2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [WDT_W-1:0] WDT_CLEAR = 8'h00;
  localparam logic [PRE_W-1:0] PRE_CLEAR = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_CALL = 3'h1,
    OP_WATCHDOG_KICK = 3'h2,
    OP_ZERO_REGISTER = 3'h3,
    OP_ZERO_ACCUMULATOR = 3'h4,
    OP_INVERT_REGISTER = 3'h5,
    OP_DECREMENT_REGISTER = 3'h6,
    OP_ROTATE_LEFT = 3'h7
  } exec_op_t;

  typedef enum logic [0:0] {
    ST_READY = 1'b0,
    ST_CALL_SECOND = 1'b1
  } exec_state_t;
endpackage : core_exec_pkg

/* rtl/core_instruction_exec_subset.sv */
`timescale 1ns/1ps
module core_instruction_exec_subset (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic op_valid_i,
  input wire logic [2:0] op_code_i,
  input wire logic [core_exec_pkg::LIT_W-1:0] call_literal_i,
  input wire logic [core_exec_pkg::FADDR_W-1:0] file_addr_i,
  input wire logic dest_to_file_i,
  input wire logic [core_exec_pkg::DATA_W-1:0] file_rdata_i,
  input wire logic [core_exec_pkg::LATCH_W-1:0] pc_upper_latch_i,
  input wire logic [core_exec_pkg::PC_W-1:0] pc_i,
  output logic op_ready_o,
  output logic [core_exec_pkg::PC_W-1:0] pc_o,
  output logic pc_load_o,
  output logic [core_exec_pkg::PC_W-1:0] stack_top_o,
  output logic stack_push_o,
  output logic file_we_o,
  output logic [core_exec_pkg::FADDR_W-1:0] file_waddr_o,
  output logic [core_exec_pkg::DATA_W-1:0] file_wdata_o,
  output logic [core_exec_pkg::DATA_W-1:0] accumulator_o,
  output logic zero_flag_o,
  output logic carry_flag_o,
  output logic watchdog_expired_flag_o,
  output logic sleep_status_flag_o,
  output logic [core_exec_pkg::WDT_W-1:0] watchdog_counter_o,
  output logic [core_exec_pkg::PRE_W-1:0] watchdog_prescaler_o,
  output logic watchdog_kick_o
);

  core_exec_pkg::exec_state_t state_ff;
  core_exec_pkg::exec_state_t nxt_state;
  logic ready_ff;
  logic nxt_ready;

  logic [core_exec_pkg::PC_W-1:0] pc_ff;
  logic [core_exec_pkg::PC_W-1:0] nxt_pc;
  logic pc_load_ff;
  logic nxt_pc_load;
  logic [core_exec_pkg::PC_W-1:0] stack_top_ff;
  logic [core_exec_pkg::PC_W-1:0] nxt_stack_top;
  logic push_ff;
  logic nxt_push;

  logic file_we_ff;
  logic nxt_file_we;
  logic [core_exec_pkg::FADDR_W-1:0] waddr_ff;
  logic [core_exec_pkg::FADDR_W-1:0] nxt_waddr;
  logic [core_exec_pkg::DATA_W-1:0] wdata_ff;
  logic [core_exec_pkg::DATA_W-1:0] nxt_wdata;

  logic [core_exec_pkg::DATA_W-1:0] acc_ff;
  logic [core_exec_pkg::DATA_W-1:0] nxt_acc;
  logic zero_ff;
  logic nxt_zero;
  logic carry_ff;
  logic nxt_carry;

  logic expired_ff;
  logic nxt_expired;
  logic sleep_ff;
  logic nxt_sleep;
  logic [core_exec_pkg::WDT_W-1:0] wdt_ff;
  logic [core_exec_pkg::WDT_W-1:0] nxt_wdt;
  logic [core_exec_pkg::PRE_W-1:0] pre_ff;
  logic [core_exec_pkg::PRE_W-1:0] nxt_pre;
  logic kick_ff;
  logic nxt_kick;

  // Decode of the presented op, shared by every state group below
  logic take;
  core_exec_pkg::exec_op_t op;
  logic do_call;
  logic do_kick;
  logic do_zero_reg;
  logic do_zero_acc;
  logic do_file_op;
  logic [core_exec_pkg::DATA_W-1:0] result;
  logic result_zero;
  logic result_carry;
  logic zero_touched;
  logic carry_touched;

  always_comb begin
    op = core_exec_pkg::exec_op_t'(op_code_i);
    // Ops presented while a call finishes are dropped, not queued
    take = op_valid_i && (state_ff == core_exec_pkg::ST_READY);
    do_call = 1'b0;
    do_kick = 1'b0;
    do_zero_reg = 1'b0;
    do_zero_acc = 1'b0;
    do_file_op = 1'b0;
    result = core_exec_pkg::DATA_ZERO;
    result_carry = carry_ff;
    zero_touched = 1'b0;
    carry_touched = 1'b0;
    if (take) begin
      unique case (op)
        core_exec_pkg::OP_NONE: begin
        end
        core_exec_pkg::OP_CALL: begin
          do_call = 1'b1;
        end
        core_exec_pkg::OP_WATCHDOG_KICK: begin
          do_kick = 1'b1;
        end
        core_exec_pkg::OP_ZERO_REGISTER: begin
          do_zero_reg = 1'b1;
        end
        core_exec_pkg::OP_ZERO_ACCUMULATOR: begin
          do_zero_acc = 1'b1;
        end
        core_exec_pkg::OP_INVERT_REGISTER: begin
          do_file_op = 1'b1;
          result = ~file_rdata_i;
          zero_touched = 1'b1;
        end
        core_exec_pkg::OP_DECREMENT_REGISTER: begin
          do_file_op = 1'b1;
          result = file_rdata_i - core_exec_pkg::DATA_ONE;
          zero_touched = 1'b1;
        end
        core_exec_pkg::OP_ROTATE_LEFT: begin
          do_file_op = 1'b1;
          // Old carry enters at the bottom; zero flag is left alone
          result = {file_rdata_i[core_exec_pkg::DATA_W-2:0], carry_ff};
          result_carry = file_rdata_i[core_exec_pkg::DATA_W-1];
          carry_touched = 1'b1;
        end
      endcase
    end
    result_zero = (result == core_exec_pkg::DATA_ZERO);
  end

  // Sequencer: a call holds off the next op for its second cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_ready = ready_ff;
    unique case (state_ff)
      core_exec_pkg::ST_READY: begin
        nxt_ready = 1'b1;
        if (do_call) begin
          nxt_state = core_exec_pkg::ST_CALL_SECOND;
          nxt_ready = 1'b0;
        end
      end
      core_exec_pkg::ST_CALL_SECOND: begin
        nxt_state = core_exec_pkg::ST_READY;
        nxt_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= core_exec_pkg::ST_READY;
      ready_ff <= 1'b0;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
    end
  end

  // Return address stacked in the first cycle, before the core moves its counter
  always_comb begin
    nxt_pc = pc_ff;
    nxt_stack_top = stack_top_ff;
    nxt_push = 1'b0;
    nxt_pc_load = 1'b0;
    if (do_call) begin
      nxt_stack_top = pc_i + core_exec_pkg::PC_ONE;
      nxt_push = 1'b1;
      nxt_pc = {pc_upper_latch_i[core_exec_pkg::LATCH_HI:core_exec_pkg::LATCH_LO],
                call_literal_i};
    end
    if (state_ff == core_exec_pkg::ST_CALL_SECOND) begin
      nxt_pc_load = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_ff <= core_exec_pkg::PC_RESET;
      pc_load_ff <= 1'b0;
      stack_top_ff <= core_exec_pkg::PC_RESET;
      push_ff <= 1'b0;
    end else if (clk_en_i) begin
      pc_ff <= nxt_pc;
      pc_load_ff <= nxt_pc_load;
      stack_top_ff <= nxt_stack_top;
      push_ff <= nxt_push;
    end
  end

  // Zero register ignores the direction bit and always writes the file
  always_comb begin
    nxt_file_we = 1'b0;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    if (do_zero_reg) begin
      nxt_file_we = 1'b1;
      nxt_waddr = file_addr_i;
      nxt_wdata = core_exec_pkg::DATA_ZERO;
    end else if (do_file_op && dest_to_file_i) begin
      nxt_file_we = 1'b1;
      nxt_waddr = file_addr_i;
      nxt_wdata = result;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      file_we_ff <= 1'b0;
      waddr_ff <= '0;
      wdata_ff <= core_exec_pkg::DATA_ZERO;
    end else if (clk_en_i) begin
      file_we_ff <= nxt_file_we;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
    end
  end

  // Accumulator and the two arithmetic flags
  always_comb begin
    nxt_acc = acc_ff;
    nxt_zero = zero_ff;
    nxt_carry = carry_ff;
    if (do_zero_acc) begin
      nxt_acc = core_exec_pkg::DATA_ZERO;
      nxt_zero = 1'b1;
    end
    if (do_zero_reg) begin
      nxt_zero = 1'b1;
    end
    if (do_file_op && !dest_to_file_i) begin
      nxt_acc = result;
    end
    if (zero_touched) begin
      nxt_zero = result_zero;
    end
    if (carry_touched) begin
      nxt_carry = result_carry;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_ff <= core_exec_pkg::DATA_ZERO;
      zero_ff <= 1'b0;
      carry_ff <= 1'b0;
    end else if (clk_en_i) begin
      acc_ff <= nxt_acc;
      zero_ff <= nxt_zero;
      carry_ff <= nxt_carry;
    end
  end

  // Counter and prescaler only ever clear here; the counting unit sits outside
  always_comb begin
    nxt_wdt = wdt_ff;
    nxt_pre = pre_ff;
    nxt_expired = expired_ff;
    nxt_sleep = sleep_ff;
    nxt_kick = 1'b0;
    if (do_kick) begin
      nxt_wdt = core_exec_pkg::WDT_CLEAR;
      nxt_pre = core_exec_pkg::PRE_CLEAR;
      nxt_kick = 1'b1;
      nxt_expired = 1'b1;
      nxt_sleep = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      expired_ff <= 1'b1;
      sleep_ff <= 1'b1;
      wdt_ff <= core_exec_pkg::WDT_CLEAR;
      pre_ff <= core_exec_pkg::PRE_CLEAR;
      kick_ff <= 1'b0;
    end else if (clk_en_i) begin
      expired_ff <= nxt_expired;
      sleep_ff <= nxt_sleep;
      wdt_ff <= nxt_wdt;
      pre_ff <= nxt_pre;
      kick_ff <= nxt_kick;
    end
  end

  assign op_ready_o = ready_ff;
  assign pc_o = pc_ff;
  assign pc_load_o = pc_load_ff;
  assign stack_top_o = stack_top_ff;
  assign stack_push_o = push_ff;
  assign file_we_o = file_we_ff;
  assign file_waddr_o = waddr_ff;
  assign file_wdata_o = wdata_ff;
  assign accumulator_o = acc_ff;
  assign zero_flag_o = zero_ff;
  assign carry_flag_o = carry_ff;
  assign watchdog_expired_flag_o = expired_ff;
  assign sleep_status_flag_o = sleep_ff;
  assign watchdog_counter_o = wdt_ff;
  assign watchdog_prescaler_o = pre_ff;
  assign watchdog_kick_o = kick_ff;

endmodule : core_instruction_exec_subset

/* verification/core_exec_checker.sv */
`timescale 1ns/1ps
module core_exec_checker (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic op_valid_i,
  input wire logic [2:0] op_code_i,
  input wire logic [10:0] call_literal_i,
  input wire logic dest_to_file_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] pc_upper_latch_i,
  input wire logic [12:0] pc_i,
  input wire logic op_ready_o,
  input wire logic [12:0] pc_o,
  input wire logic pc_load_o,
  input wire logic [12:0] stack_top_o,
  input wire logic stack_push_o,
  input wire logic file_we_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic [7:0] accumulator_o,
  input wire logic zero_flag_o,
  input wire logic carry_flag_o,
  input wire logic watchdog_expired_flag_o,
  input wire logic sleep_status_flag_o,
  input wire logic [7:0] watchdog_counter_o,
  input wire logic [7:0] watchdog_prescaler_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic tk;
  logic [1:0] up_bits;
  logic f_msb;
  assign tk = clk_en_i && op_valid_i && op_ready_o;
  assign up_bits = pc_upper_latch_i[4:3];
  assign f_msb = file_rdata_i[7];
  sequence s_call_taken;
    tk && op_code_i == 3'h1;
  endsequence
  sequence s_push_then_load;
    stack_push_o && !op_ready_o ##1 pc_load_o && !stack_push_o;
  endsequence
  a_call_two_cycles: assert property (s_call_taken ##1 clk_en_i |-> s_push_then_load)
    else $error("call sequencing wrong");
  a_call_target: assert property (s_call_taken |=>
    stack_top_o == $past(pc_i) + 13'h0001 && pc_o == {$past(up_bits), $past(call_literal_i)})
    else $error("call target wrong");
  a_kick_effects: assert property (tk && op_code_i == 3'h2 |=>
    watchdog_counter_o == 8'h00 && watchdog_prescaler_o == 8'h00 && watchdog_expired_flag_o
    && sleep_status_flag_o && $stable(zero_flag_o) && $stable(carry_flag_o))
    else $error("kick wrong");
  a_zero_register: assert property (tk && op_code_i == 3'h3 |=>
    file_we_o && file_wdata_o == 8'h00 && zero_flag_o) else $error("zero register wrong");
  a_zero_acc: assert property (tk && op_code_i == 3'h4 |=>
    accumulator_o == 8'h00 && zero_flag_o) else $error("zero accumulator wrong");
  a_invert_zero: assert property (tk && op_code_i == 3'h5 |=>
    zero_flag_o == ($past(file_rdata_i) == 8'hff) && $stable(carry_flag_o)) else $error("invert");
  a_decrement_dest: assert property (tk && op_code_i == 3'h6 && dest_to_file_i |=>
    file_we_o && file_wdata_o == $past(file_rdata_i) - 8'h01) else $error("decrement wrong");
  a_rotate_carry: assert property (tk && op_code_i == 3'h7 |=>
    carry_flag_o == $past(f_msb) && $stable(zero_flag_o)) else $error("rotate carry wrong");
endmodule : core_exec_checker
bind core_instruction_exec_subset core_exec_checker u_chk (.*);

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, op_valid_i = 1'b0;
  logic dest_to_file_i = 1'b0;
  logic [2:0] op_code_i = 3'h0;
  logic [10:0] call_literal_i = 11'h000;
  logic [6:0] file_addr_i = 7'h00, file_waddr_o;
  logic [7:0] file_rdata_i = 8'h00, pc_upper_latch_i = 8'h00;
  logic [12:0] pc_i = 13'h0000, pc_o, stack_top_o;
  logic op_ready_o, pc_load_o, stack_push_o, file_we_o, zero_flag_o, carry_flag_o;
  logic watchdog_expired_flag_o, sleep_status_flag_o, watchdog_kick_o;
  logic [7:0] file_wdata_o, accumulator_o, watchdog_counter_o, watchdog_prescaler_o;
  int failures = 0, n_tests = 0, cyc = 0;
  // Code, f, direction, result, {we, zero, carry, 0}
  localparam logic [27:0] TBL [9] = '{28'h35a000c, 28'h5ff0004, 28'h55a1a58, 28'h601100c,
    28'h6000ff0, 28'h4000004, 28'h7800006, 28'h701103c, 28'h2000004};
  core_instruction_exec_subset u_dut (.*);
  always #50 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string n, input logic [12:0] s, input logic [12:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Valid stands for one edge only, so back-to-back calls never double-drive it
  task automatic op(input logic [2:0] c, input logic [7:0] f, input logic d);
    @(negedge clk_sys_i);
    op_valid_i = 1'b1;
    op_code_i = c;
    file_rdata_i = f;
    dest_to_file_i = d;
    @(negedge clk_sys_i);
    op_valid_i = 1'b0;
    file_rdata_i = ~f;
  endtask : op
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 500) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    @(negedge clk_sys_i);
    pc_i = 13'h0123;
    call_literal_i = 11'h7ff;
    pc_upper_latch_i = 8'h10;
    op(3'h1, 8'h00, 1'b0);
    chk("push", stack_push_o, 1'b1);
    chk("stack", stack_top_o, 13'h0124);
    chk("pc", pc_o, 13'h17ff);
    chk("ready", op_ready_o, 1'b0);
    @(negedge clk_sys_i);
    chk("load", pc_load_o, 1'b1);
    chk("push end", stack_push_o, 1'b0);
    chk("ready again", op_ready_o, 1'b1);
    $display("call test done");
    file_addr_i = 7'h7f;
    for (int i = 0; i < 9; i++) begin
      op(TBL[i][26:24], TBL[i][23:16], TBL[i][12]);
      chk("we", file_we_o, TBL[i][3]);
      chk("result", TBL[i][3] ? file_wdata_o : accumulator_o,
        TBL[i][11:4]);
      chk("zero", zero_flag_o, TBL[i][2]);
      chk("carry", carry_flag_o, TBL[i][1]);
      if (TBL[i][3]) begin
        chk("addr", file_waddr_o, 7'h7f);
      end
    end
    chk("kick", {watchdog_kick_o, watchdog_expired_flag_o, sleep_status_flag_o,
      watchdog_counter_o}, 11'h700);
    chk("prescaler", watchdog_prescaler_o, 8'h00);
    $display("file op test done");
    op(3'h0, 8'h33, 1'b1);
    chk("idle we", file_we_o, 1'b0);
    chk("idle acc", accumulator_o, 8'h00);
    chk("idle flags", {zero_flag_o, carry_flag_o, watchdog_kick_o}, 3'h4);
    clk_en_i = 1'b0;
    op(3'h6, 8'h10, 1'b0);
    chk("frozen acc", accumulator_o, 8'h00);
    chk("frozen zero", zero_flag_o, 1'b1);
    clk_en_i = 1'b1;
    op(3'h6, 8'h10, 1'b0);
    chk("dec acc", accumulator_o, 8'h0f);
    chk("dec zero", zero_flag_o, 1'b0);
    $display("idle and enable test done");
    rst_n_i = 1'b0;
    @(negedge clk_sys_i);
    chk("reset acc", accumulator_o, 8'h00);
    chk("reset pc", pc_o, 13'h0000);
    chk("reset flags", {op_ready_o, zero_flag_o, watchdog_expired_flag_o,
      sleep_status_flag_o}, 4'h3);
    rst_n_i = 1'b1;
    @(negedge clk_sys_i);
    chk("ready after reset", op_ready_o, 1'b1);
    $display("reset test done");
    final_report();
  end
endmodule : tb_top
